/* shared/aprv_pkg.sv */
// Package for the pair ready status and jump table vector block
package aprv_pkg;
	localparam int          NUM_PAIRS      = 6;
	localparam int          REG_W          = 16;
	localparam int          IDX_SHIFT      = 2;
	localparam logic [11:0] OFF_STATUS     = 12'h000;
	localparam logic [11:0] OFF_BASE       = 12'h004;
	localparam logic [15:0] STATUS_RESET   = 16'h0000;
	localparam logic [15:0] BASE_RESET     = 16'h0000;
	localparam logic [15:0] BASE_WR_MASK   = 16'hFFFE;
	localparam logic [5:0]  PAIR_MASK      = 6'h3F;

	typedef enum logic [1:0] {
		APRV_IDLE   = 2'b00,
		APRV_ACCESS = 2'b01
	} aprv_phase_t;

	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [3:0]  strb;
	} aprv_apb_req_t;
endpackage

/* core/aprv_prio_enc.sv */
// Priority encoder: lowest set bit number wins
module aprv_prio_enc #(
	parameter int N = 6,
	parameter int W = 3
) (
	// Flags in
	input  wire logic [N-1:0] flags,
	// Encoded index out
	output logic      [W-1:0] index
);
	always_comb
	begin
		index = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (flags[i])
			begin
				index = W'(i);
			end
		end
	end
endmodule

/* core/aprv_top.sv */
// Pair ready status flags and vectored jump table base register over APB
// Functional notes
// - Six ready flags sit in status bits 5..0 and hardware sets one when its pair result lands in the buffer.
// - A ready flag is cleared only by software writing zero to its position, and software clears serviced flags so.
// - The base register keeps software written bits 15..1 and resets to zero.
// - Base bit 0 is not stored, reads zero and ignores writes.
// - Reading the base returns the stored base plus the encoded flag index.
// - The encoder gives the number of the lowest numbered set flag, pair zero being highest priority.
// - The index is shifted left two places before the add so its low two bits are zero.
// - A separate completion interrupt per pair is offered as an alternative to the vectored read.
module aprv_top (
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        RSTN,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Converter side
	input  wire logic [5:0]  PAIR_DONE,
	output logic      [5:0]  PAIR_COMPLETE_IRQ
);
	// Bus request as one bundle
	aprv_pkg::aprv_apb_req_t req;

	// Decode and transfer qualifiers
	logic                  hit_status;
	logic                  hit_base;
	logic                  hit_any;
	logic                  setup;
	logic                  access;
	logic                  wr_take;
	logic                  status_wr;
	logic                  base_wr;

	// Transfer phase
	aprv_pkg::aprv_phase_t phase_q;
	aprv_pkg::aprv_phase_t phase_d;

	// Pair ready flags
	logic      [5:0]       ready_q;
	logic      [5:0]       ready_d;
	wire logic [5:0]       flag_clr;
	wire logic [5:0]       flag_set;

	// Jump table base and vector
	logic      [15:0]      base_q;
	logic      [15:0]      base_d;
	logic      [2:0]       enc_idx;
	logic      [15:0]      idx_offset;
	logic      [15:0]      vector;

	// Bus answer
	logic      [31:0]      prdata_q;
	logic      [31:0]      prdata_d;
	logic                  pready_q;
	logic                  pready_d;
	logic                  pslverr_q;
	logic                  pslverr_d;

	// Completion interrupts
	logic      [5:0]       irq_q;
	logic      [5:0]       irq_d;

	genvar                 g;

	assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA, strb: PSTRB};

	aprv_prio_enc #(
		.N (aprv_pkg::NUM_PAIRS),
		.W (3)
	) u_enc (
		.flags (ready_q),
		.index (enc_idx)
	);

	// Decode: reads answer from the setup edge, writes commit at the access edge
	always_comb
	begin
		hit_status = (req.addr == aprv_pkg::OFF_STATUS);
		hit_base   = (req.addr == aprv_pkg::OFF_BASE);
		hit_any    = hit_status || hit_base;
		setup      = req.sel && !req.enable;
		// Only an access that follows our own setup edge may write, so a stray enable is harmless
		access     = req.sel && req.enable && (phase_q == aprv_pkg::APRV_ACCESS);
		wr_take    = access && req.write;
		status_wr  = wr_take && hit_status && req.strb[0];
		base_wr    = wr_take && hit_base;
	end

	// Transfer phase: zero wait states, so access always lasts one cycle
	always_comb
	begin
		phase_d = aprv_pkg::APRV_IDLE;
		case (phase_q)
			aprv_pkg::APRV_IDLE:
			begin
				if (setup)
				begin
					phase_d = aprv_pkg::APRV_ACCESS;
				end
			end
			aprv_pkg::APRV_ACCESS:
			begin
				// A back-to-back setup is seen next cycle from idle
				phase_d = aprv_pkg::APRV_IDLE;
			end
			default:
			begin
				phase_d = aprv_pkg::APRV_IDLE;
			end
		endcase
	end

	// One clear term and one set term per pair
	generate
		for (g = 0; g < aprv_pkg::NUM_PAIRS; g = g + 1)
		begin : g_flag
			assign flag_clr[g] = status_wr && !req.wdata[g];
			assign flag_set[g] = PAIR_DONE[g];
		end
	endgenerate

	// Set is applied after clear so a completion in the clearing cycle is not lost
	always_comb
	begin
		ready_d = ((ready_q & ~flag_clr) | flag_set) & aprv_pkg::PAIR_MASK;
	end

	// Base register, written per byte lane
	always_comb
	begin
		base_d = base_q;
		if (base_wr && req.strb[0])
		begin
			// Bit 0 has no storage, so a written one is dropped here
			base_d[7:0] = req.wdata[7:0] & aprv_pkg::BASE_WR_MASK[7:0];
		end
		if (base_wr && req.strb[1])
		begin
			base_d[15:8] = req.wdata[15:8];
		end
	end

	// The add wraps at 16 bits: a base near the top of the map folds back to low addresses
	always_comb
	begin
		idx_offset = 16'(enc_idx) << aprv_pkg::IDX_SHIFT;
		vector     = base_q + idx_offset;
	end

	// Answer is registered at the setup edge and stands for the access cycle only
	always_comb
	begin
		pready_d  = setup;
		pslverr_d = setup && !hit_any;
		prdata_d  = 32'h0000_0000;
		if (setup && !req.write && hit_status)
		begin
			prdata_d = {26'h0, ready_q};
		end
		else if (setup && !req.write && hit_base)
		begin
			prdata_d = {16'h0000, vector};
		end
	end

	// Completion interrupts follow the converter one cycle late
	always_comb
	begin
		irq_d = PAIR_DONE;
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			phase_q <= aprv_pkg::APRV_IDLE;
		end
		else
		begin
			phase_q <= phase_d;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			ready_q <= aprv_pkg::STATUS_RESET[5:0];
		end
		else
		begin
			ready_q <= ready_d;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			base_q <= aprv_pkg::BASE_RESET;
		end
		else
		begin
			base_q <= base_d;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			irq_q <= 6'h00;
		end
		else
		begin
			irq_q <= irq_d;
		end
	end

	// Every output comes straight from a flip-flop
	assign PRDATA            = prdata_q;
	assign PREADY            = pready_q;
	assign PSLVERR           = pslverr_q;
	assign PAIR_COMPLETE_IRQ = irq_q;
endmodule

/* verif/aprv_top_props.sv */
// Checker for the pair ready vector block
module aprv_chk (
	// Bus and converter
	input wire logic        CORE_CLK,
	input wire logic        RSTN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic [5:0]  PAIR_DONE,
	input wire logic [5:0]  PAIR_COMPLETE_IRQ
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	logic su;
	assign su = PSEL && !PENABLE;
	property p_rdy; su |=> PREADY; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_irq; PAIR_DONE != 0 |=> PAIR_COMPLETE_IRQ == $past(PAIR_DONE); endproperty
	a_irq: assert property (p_irq) else $error("irq");
	property p_set; PAIR_DONE[0] ##1 (su && !PWRITE && PADDR == 12'h000) |=> PRDATA[0]; endproperty
	a_set: assert property (p_set) else $error("flag");
	property p_hi; PREADY && !PWRITE && PADDR == 12'h000 |-> PRDATA[31:6] == 26'h0; endproperty
	a_hi: assert property (p_hi) else $error("high");
	property p_b0; PREADY && !PWRITE && PADDR == 12'h004 |-> !PRDATA[0]; endproperty
	a_b0: assert property (p_b0) else $error("bit0");
	property p_err; su && PADDR != 12'h000 && PADDR != 12'h004 |=> PSLVERR && PRDATA == 32'h0; endproperty
	a_err: assert property (p_err) else $error("err");
	property p_one; PREADY |=> !PREADY; endproperty
	a_one: assert property (p_one) else $error("pulse");
	property p_idle; !PREADY |-> PRDATA == 32'h0 && !PSLVERR; endproperty
	a_idle: assert property (p_idle) else $error("idle");
endmodule
bind aprv_top aprv_chk u_chk (.CORE_CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
	.PAIR_DONE, .PAIR_COMPLETE_IRQ);

/* verif/test_adc_pair_ready_vector.sv */
// Bench for the pair ready vector block
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("Error %0t %h %h", $time, a, b); end end
module test_adc_pair_ready_vector;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 0, rstn = 0, sel = 0, en = 0, wr = 0, rdy, err, e;
	logic [11:0] addr = 0;
	logic [31:0] wd = 0, rd, q;
	logic [5:0]  done = 0, irq;
	logic [3:0]  strb = 4'hF;
	int          n_mismatch = 0, comparisons = 0;
	always #12.5 clk = ~clk;
	aprv_top u_aprv_top (.CORE_CLK(clk), .RSTN(rstn), .PSEL(sel), .PENABLE(en), .PWRITE(wr), .PADDR(addr),
		.PWDATA(wd), .PSTRB(strb), .PRDATA(rd), .PREADY(rdy), .PSLVERR(err), .PAIR_DONE(done),
		.PAIR_COMPLETE_IRQ(irq));
	task wrap_up;
		if (n_mismatch == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Pd is raised only in the access cycle, to race a status clear
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [5:0] pd);
		int n;
		@(posedge clk);
		sel <= 1; en <= 0; wr <= w; addr <= a; wd <= d;
		@(posedge clk);
		en <= 1; done <= pd; n = 0;
		@(posedge clk);
		while (!rdy && n < 20)
		begin
			n++;
			@(posedge clk);
		end
		if (!rdy)
		begin
			n_mismatch++;
			wrap_up;
		end
		else
		begin
			q = rd; e = err;
			sel <= 0; en <= 0; done <= 0;
		end
	endtask
	task t_vector;
		apb(0, 12'h004, 0, 0); `CHK(q, 32'h0)
		apb(1, 12'h004, 32'h1235, 0);
		apb(1, 12'h008, 0, 6'h3F); `CHK(e, 1'b1)
		apb(0, 12'h000, 0, 0); `CHK(q, 32'h3F)
		for (int i = 0; i < 6; i++)
		begin
			apb(0, 12'h004, 0, 0); `CHK(q, 32'h1234 + (i << 2))
			apb(1, 12'h000, ~(32'h1 << i), 0);
		end
		apb(0, 12'h000, 0, 0); `CHK(q, 32'h0)
		apb(0, 12'h004, 0, 0); `CHK(q, 32'h1234)
	endtask
	task t_race;
		apb(1, 12'h000, 0, 6'h04);
		apb(0, 12'h000, 0, 0); `CHK(q, 32'h4)
		apb(0, 12'h004, 0, 0); `CHK(q, 32'h123C)
	endtask
	// Completion held over a status setup: interrupt one cycle late, flag read back set afterwards
	task t_irq;
		@(posedge clk);
		done <= 6'h21;
		@(posedge clk);
		`CHK(irq, 6'h00)
		@(posedge clk);
		`CHK(irq, 6'h21)
		apb(0, 12'h000, 0, 6'h00); `CHK(q, 32'h25)
		@(posedge clk);
		`CHK(irq, 6'h00)
	endtask
	// Lane zero off: the status clear is dropped and only the upper base byte lands
	task t_strb;
		strb <= 4'hE;
		apb(1, 12'h000, 0, 0);
		apb(0, 12'h000, 0, 0); `CHK(q, 32'h25)
		apb(1, 12'h004, 32'h0000_ABCD, 0);
		apb(0, 12'h004, 0, 0); `CHK(q, 32'hAB34)
		strb <= 4'hF;
		apb(1, 12'h000, 32'hFFFF_FFDE, 0);
		apb(0, 12'h004, 0, 0); `CHK(q, 32'hAB3C)
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rstn <= 1;
		t_vector;
		t_race;
		t_irq;
		t_strb;
		wrap_up;
	end
endmodule
